// File: design/core_and_port_register_map.sv
// core and port register bank behind an APB slave
// Operation
// - indirect windows access memory through pointer pairs
// - core registers decode identically in every bank
// - unimplemented locations and bits read zero
// - upper counter latch is seven bits, applied later
// - power-on resets all; external reset keeps some
// - port C registers exist only on large variant
`timescale 1ns/100ps
module core_and_port_register_map
	import core_regs_pkg::*;
#(
	parameter bit HAS_PORT_C = 1'b1
)
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic externalResetPinN,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [8:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic pcStep,
	output logic [PC_W-1:0] pcValue,
	input wire logic [5:0] portAIn,
	output logic [5:0] portAOut,
	output logic [5:0] portAOe,
	input wire logic [5:0] portCIn,
	output logic [5:0] portCOut,
	output logic [5:0] portCOe
);
	logic [7:0] flags_reg, flags_next;
	logic [7:0] ptr0Low_reg, ptr0Low_next;
	logic [7:0] ptr0High_reg, ptr0High_next;
	logic [7:0] ptr1Low_reg, ptr1Low_next;
	logic [7:0] ptr1High_reg, ptr1High_next;
	logic [7:0] bankSel_reg, bankSel_next;
	logic [7:0] accum_reg, accum_next;
	logic [7:0] pcLatch_reg, pcLatch_next;
	logic [7:0] intCtrl_reg, intCtrl_next;
	logic [7:0] portADir_reg, portADir_next;
	logic [7:0] portCDir_reg, portCDir_next;
	logic [7:0] portALat_reg, portALat_next;
	logic [7:0] portCLat_reg, portCLat_next;
	logic [PC_W-1:0] pc_reg, pc_next;
	logic phaseDone_reg, phaseDone_next;
	logic ramRead_reg, ramRead_next;
	logic [7:0] readHold_reg, readHold_next;
	logic [1:0] extResetSync_reg;
	logic [5:0] portAMeta_reg, portASync_reg;
	logic [5:0] portCMeta_reg, portCSync_reg;
	logic [12:0] directAddr;
	logic [12:0] effAddr;
	logic isIndirect;
	logic nullAccess;
	logic ramHit;
	logic inBank0;
	logic [7:0] readValue;
	logic [7:0] wrData;
	logic wrStrobe;
	logic extReset;
	logic [7:0] ramData;

	// pin and external reset synchronisers
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			extResetSync_reg <= 2'h3;
			portAMeta_reg <= 6'h00;
			portASync_reg <= 6'h00;
			portCMeta_reg <= 6'h00;
			portCSync_reg <= 6'h00;
		end
		else
		begin
			extResetSync_reg <= {extResetSync_reg[0], externalResetPinN};
			portAMeta_reg <= portAIn;
			portASync_reg <= portAMeta_reg;
			portCMeta_reg <= portCIn;
			portCSync_reg <= portCMeta_reg;
		end
	end

	assign extReset = ~extResetSync_reg[1];

	// address resolution for direct and indirect accesses
	always_comb
	begin
		directAddr = {bankSel_reg[5:0], paddr[8:2]};
		effAddr = directAddr;
		isIndirect = 1'b0;
		if (directAddr[6:0] == OFF_INDIRECT0)
		begin
			effAddr = {ptr0High_reg[4:0], ptr0Low_reg};
			isIndirect = 1'b1;
		end
		else if (directAddr[6:0] == OFF_INDIRECT1)
		begin
			effAddr = {ptr1High_reg[4:0], ptr1Low_reg};
			isIndirect = 1'b1;
		end
		// a window pointing at a window reaches nothing
		nullAccess = isIndirect && (effAddr[6:0] == OFF_INDIRECT0 ||
			effAddr[6:0] == OFF_INDIRECT1);
		ramHit = !nullAccess && (effAddr[12:7] < GPR_BANKS) && (effAddr[6:0] >= GPR_FIRST);
		inBank0 = (effAddr[12:7] == 6'h00);
	end

	// read multiplexer over the resolved address
	always_comb
	begin
		readValue = RST_ZERO;
		if (!nullAccess)
		begin
			unique case (effAddr[6:0])
				OFF_PC_LOW: readValue = pc_reg[7:0];
				OFF_FLAGS: readValue = flags_reg & MASK_FLAGS_RD;
				OFF_PTR0_LOW: readValue = ptr0Low_reg;
				OFF_PTR0_HIGH: readValue = ptr0High_reg;
				OFF_PTR1_LOW: readValue = ptr1Low_reg;
				OFF_PTR1_HIGH: readValue = ptr1High_reg;
				OFF_BANK_SEL: readValue = bankSel_reg & MASK_BANK_SEL;
				OFF_ACCUM: readValue = accum_reg;
				OFF_PC_LATCH: readValue = pcLatch_reg & MASK_PC_LATCH;
				OFF_INT_CTRL: readValue = intCtrl_reg & MASK_INT_CTRL;
				OFF_PORT_A_PINS_PINS: readValue = inBank0 ? {2'h0, portASync_reg} : RST_ZERO;
				OFF_PORT_A_PINS_DIR: readValue = inBank0 ? (portADir_reg & MASK_PORT_A_PINS_LAT) : RST_ZERO;
				OFF_PORT_A_PINS_LAT: readValue = inBank0 ? (portALat_reg & MASK_PORT_A_PINS_LAT) : RST_ZERO;
				OFF_PORT_C_PINS_PINS: readValue = (inBank0 && HAS_PORT_C) ?
					{2'h0, portCSync_reg} : RST_ZERO;
				OFF_PORT_C_PINS_DIR: readValue = (inBank0 && HAS_PORT_C) ?
					(portCDir_reg & MASK_PORT_C_PINS) : RST_ZERO;
				OFF_PORT_C_PINS_LAT: readValue = (inBank0 && HAS_PORT_C) ?
					(portCLat_reg & MASK_PORT_C_PINS) : RST_ZERO;
				default: readValue = RST_ZERO;
			endcase
		end
	end

	// bus phase tracking: one wait cycle, then pready
	assign wrData = pwdata[7:0];
	assign wrStrobe = psel && penable && pwrite && phaseDone_reg && !extReset;
	always_comb
	begin
		phaseDone_next = psel && penable && !phaseDone_reg;
		ramRead_next = ramRead_reg;
		readHold_next = readHold_reg;
		if (psel && penable && !phaseDone_reg)
		begin
			ramRead_next = ramHit;
			readHold_next = readValue;
		end
	end

	// next values of the core and port registers
	always_comb
	begin
		flags_next = flags_reg;
		ptr0Low_next = ptr0Low_reg;
		ptr0High_next = ptr0High_reg;
		ptr1Low_next = ptr1Low_reg;
		ptr1High_next = ptr1High_reg;
		bankSel_next = bankSel_reg;
		accum_next = accum_reg;
		pcLatch_next = pcLatch_reg;
		intCtrl_next = intCtrl_reg;
		portADir_next = portADir_reg;
		portCDir_next = portCDir_reg;
		portALat_next = portALat_reg;
		portCLat_next = portCLat_reg;
		pc_next = pcStep ? PC_W'(pc_reg + 1'b1) : pc_reg;
		if (wrStrobe && !nullAccess)
		begin
			unique case (effAddr[6:0])
				OFF_PC_LOW: pc_next = {pcLatch_reg[6:0], wrData};
				OFF_FLAGS: flags_next = (flags_reg & ~MASK_FLAGS_WR) | (wrData & MASK_FLAGS_WR);
				OFF_PTR0_LOW: ptr0Low_next = wrData;
				OFF_PTR0_HIGH: ptr0High_next = wrData;
				OFF_PTR1_LOW: ptr1Low_next = wrData;
				OFF_PTR1_HIGH: ptr1High_next = wrData;
				OFF_BANK_SEL: bankSel_next = wrData & MASK_BANK_SEL;
				OFF_ACCUM: accum_next = wrData;
				OFF_PC_LATCH: pcLatch_next = wrData & MASK_PC_LATCH;
				OFF_INT_CTRL: intCtrl_next = wrData & MASK_INT_CTRL;
				OFF_PORT_A_PINS_PINS:
				begin
					if (inBank0)
					begin
						portALat_next = wrData & MASK_PORT_A_PINS_LAT;
					end
				end
				OFF_PORT_A_PINS_DIR:
				begin
					if (inBank0)
					begin
						portADir_next = wrData & MASK_PORT_A_PINS_LAT;
					end
				end
				OFF_PORT_A_PINS_LAT:
				begin
					if (inBank0)
					begin
						portALat_next = wrData & MASK_PORT_A_PINS_LAT;
					end
				end
				OFF_PORT_C_PINS_PINS, OFF_PORT_C_PINS_LAT:
				begin
					if (inBank0 && HAS_PORT_C)
					begin
						portCLat_next = wrData & MASK_PORT_C_PINS;
					end
				end
				OFF_PORT_C_PINS_DIR:
				begin
					if (inBank0 && HAS_PORT_C)
					begin
						portCDir_next = wrData & MASK_PORT_C_PINS;
					end
				end
				default: ;
			endcase
		end
		// external reset: reset all but accumulator, low pointers, port latches, flags
		if (extReset)
		begin
			pc_next = '0;
			ptr0High_next = RST_ZERO;
			ptr1High_next = RST_ZERO;
			bankSel_next = RST_ZERO;
			pcLatch_next = RST_ZERO;
			intCtrl_next = RST_INT_CTRL;
			portADir_next = RST_PORT_A_PINS_DIR;
			portCDir_next = RST_PORT_C_PINS_DIR;
		end
	end

	// register stage; power-on reset loads every register with its reset value
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			flags_reg <= RST_FLAGS;
			ptr0Low_reg <= RST_ZERO;
			ptr0High_reg <= RST_ZERO;
			ptr1Low_reg <= RST_ZERO;
			ptr1High_reg <= RST_ZERO;
			bankSel_reg <= RST_ZERO;
			accum_reg <= RST_ZERO;
			pcLatch_reg <= RST_ZERO;
			intCtrl_reg <= RST_INT_CTRL;
			portADir_reg <= RST_PORT_A_PINS_DIR;
			portCDir_reg <= RST_PORT_C_PINS_DIR;
			portALat_reg <= RST_ZERO;
			portCLat_reg <= RST_ZERO;
			pc_reg <= '0;
			phaseDone_reg <= 1'b0;
			ramRead_reg <= 1'b0;
			readHold_reg <= RST_ZERO;
		end
		else
		begin
			flags_reg <= flags_next;
			ptr0Low_reg <= ptr0Low_next;
			ptr0High_reg <= ptr0High_next;
			ptr1Low_reg <= ptr1Low_next;
			ptr1High_reg <= ptr1High_next;
			bankSel_reg <= bankSel_next;
			accum_reg <= accum_next;
			pcLatch_reg <= pcLatch_next;
			intCtrl_reg <= intCtrl_next;
			portADir_reg <= portADir_next;
			portCDir_reg <= portCDir_next;
			portALat_reg <= portALat_next;
			portCLat_reg <= portCLat_next;
			pc_reg <= pc_next;
			phaseDone_reg <= phaseDone_next;
			ramRead_reg <= ramRead_next;
			readHold_reg <= readHold_next;
		end
	end

	// data memory reached directly or through a window
	gp_ram ram (
		.ref_clk(ref_clk),
		.writeEn(wrStrobe && ramHit),
		.writeAddr({effAddr[7], effAddr[6:0]}),
		.writeData(wrData),
		.readAddr({effAddr[7], effAddr[6:0]}),
		.readData(ramData)
	);

	// bus answer and pin drive
	assign pready = psel && penable && phaseDone_reg;
	assign prdata = {24'h00_0000, (ramRead_reg ? ramData : readHold_reg)};
	assign pslverr = 1'b0;
	assign pcValue = pc_reg;
	assign portAOut = portALat_reg[5:0] & MASK_PORT_A_PINS_LAT[5:0];
	assign portAOe = ~portADir_reg[5:0] & MASK_PORT_A_PINS_LAT[5:0];
	assign portCOut = HAS_PORT_C ? portCLat_reg[5:0] : 6'h00;
	assign portCOe = HAS_PORT_C ? ~portCDir_reg[5:0] : 6'h00;
endmodule : core_and_port_register_map

// File: design/gp_ram.sv
// general purpose data memory with registered read data
`timescale 1ns/100ps
module gp_ram
	import core_regs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic writeEn,
	input wire logic [RAM_AW-1:0] writeAddr,
	input wire logic [7:0] writeData,
	input wire logic [RAM_AW-1:0] readAddr,
	output logic [7:0] readData
);
	logic [7:0] mem [0:(1<<RAM_AW)-1];

	// write port and registered read port
	always_ff @(posedge ref_clk)
	begin
		if (writeEn)
		begin
			mem[writeAddr] <= writeData;
		end
		readData <= mem[readAddr];
	end
endmodule : gp_ram

// File: inc/core_regs_pkg.sv
// constants for the core and port register bank
package core_regs_pkg;
	// register indices within a bank (byte address is four times the index)
	localparam logic [6:0] OFF_INDIRECT0 = 7'h00;
	localparam logic [6:0] OFF_INDIRECT1 = 7'h01;
	localparam logic [6:0] OFF_PC_LOW = 7'h02;
	localparam logic [6:0] OFF_FLAGS = 7'h03;
	localparam logic [6:0] OFF_PTR0_LOW = 7'h04;
	localparam logic [6:0] OFF_PTR0_HIGH = 7'h05;
	localparam logic [6:0] OFF_PTR1_LOW = 7'h06;
	localparam logic [6:0] OFF_PTR1_HIGH = 7'h07;
	localparam logic [6:0] OFF_BANK_SEL = 7'h08;
	localparam logic [6:0] OFF_ACCUM = 7'h09;
	localparam logic [6:0] OFF_PC_LATCH = 7'h0a;
	localparam logic [6:0] OFF_INT_CTRL = 7'h0b;
	localparam logic [6:0] OFF_PORT_A_PINS_PINS = 7'h0c;
	localparam logic [6:0] OFF_PORT_C_PINS_PINS = 7'h0e;
	localparam logic [6:0] OFF_PORT_A_PINS_DIR = 7'h12;
	localparam logic [6:0] OFF_PORT_C_PINS_DIR = 7'h14;
	localparam logic [6:0] OFF_PORT_A_PINS_LAT = 7'h18;
	localparam logic [6:0] OFF_PORT_C_PINS_LAT = 7'h1a;
	// general purpose memory: offsets from GPR_FIRST up, banks below GPR_BANKS
	localparam logic [6:0] GPR_FIRST = 7'h20;
	localparam logic [5:0] GPR_BANKS = 6'h02;
	localparam int RAM_AW = 8;
	localparam int PC_W = 15;
	// reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_FLAGS = 8'h18;
	localparam logic [7:0] RST_INT_CTRL = 8'h01;
	localparam logic [7:0] RST_PORT_A_PINS_DIR = 8'h37;
	localparam logic [7:0] RST_PORT_C_PINS_DIR = 8'h3f;
	// implemented bit masks
	localparam logic [7:0] MASK_FLAGS_WR = 8'h07;
	localparam logic [7:0] MASK_FLAGS_RD = 8'h1f;
	localparam logic [7:0] MASK_BANK_SEL = 8'h3f;
	localparam logic [7:0] MASK_PC_LATCH = 8'h7f;
	localparam logic [7:0] MASK_INT_CTRL = 8'hc1;
	localparam logic [7:0] MASK_PORT_A_PINS_PINS = 8'h3f;
	localparam logic [7:0] MASK_PORT_A_PINS_LAT = 8'h37;
	localparam logic [7:0] MASK_PORT_C_PINS = 8'h3f;
endpackage : core_regs_pkg

// File: tb/core_master.sv
// processor core side: issues register reads and writes over the bus
`timescale 1ns/100ps
module core_master
(
	input wire logic ref_clk,
	input wire logic pready,
	input wire logic [31:0] prdata,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [8:0] paddr,
	output logic [31:0] pwdata
);
	// bus idle at time zero
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 9'h000;
		pwdata = 32'h0000_0000;
	end
	// setup, access held until ready is sampled at a rising edge, then release right after it
	task automatic xfer(input logic w, input logic [6:0] idx, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h00_0000, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		do
			@(posedge ref_clk);
		while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : core_master

// File: tb/core_regs_monitor.sv
// bus timing and output checks for the core register bank
`timescale 1ns/100ps
module core_regs_monitor
	import core_regs_pkg::*;
#(
	parameter bit HAS_PORT_C = 1'b1
)
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic externalResetPinN,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [8:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic pcStep,
	input wire logic [PC_W-1:0] pcValue,
	input wire logic [5:0] portAOut,
	input wire logic [5:0] portAOe,
	input wire logic [5:0] portCOut,
	input wire logic [5:0] portCOe
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// completed write, and completed write to the counter low byte
	wire logic doneWr = psel & penable & pready & pwrite;
	wire logic pcWr = doneWr & (paddr[8:2] == OFF_PC_LOW);
	wait_state_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("no single wait state");
	ready_access_a: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	no_error_a: assert property (!pslverr) else $error("error response");
	upper_zero_a: assert property (prdata[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	port_a_pins_bit3_a: assert property (!portAOut[3] && !portAOe[3])
		else $error("port A bit 3 active");
	port_c_pins_absent_a: assert property (!HAS_PORT_C |-> portCOut == 6'h00 && portCOe == 6'h00)
		else $error("port C active when absent");
	pc_step_a: assert property (pcStep && !doneWr && $past(externalResetPinN, 2) |=>
		pcValue == $past(pcValue) + 1'b1) else $error("counter step wrong");
	pc_load_a: assert property (pcWr && $past(externalResetPinN, 2) |=>
		pcValue[7:0] == $past(pwdata[7:0])) else $error("counter load wrong");
	ext_clear_a: assert property (!externalResetPinN [*3] |=> pcValue == 15'h0000)
		else $error("counter kept in pin reset");
endmodule : core_regs_monitor

bind core_and_port_register_map core_regs_monitor #(.HAS_PORT_C(HAS_PORT_C)) mon (
	.ref_clk, .nrst, .externalResetPinN, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pready, .prdata, .pslverr, .pcStep, .pcValue, .portAOut, .portAOe, .portCOut, .portCOe);

// File: tb/testbench.sv
// self-checking bench for the core and port register bank
`timescale 1ns/100ps
module testbench
	import core_regs_pkg::*;
;
	logic ref_clk, nrst, externalResetPinN, pcStep, psel, penable, pwrite, pready, pslverr;
	logic [8:0] paddr;
	logic [31:0] pwdata, prdata, prdataSmall, q;
	logic [PC_W-1:0] pcValue;
	logic [5:0] portAIn, portAOut, portAOe, portCIn, portCOut, portCOe;
	int failures = 0;
	int checks = 0;
	int cycles = 0;
	core_master m (.ref_clk, .pready, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata);
	core_and_port_register_map uut (.ref_clk, .nrst, .externalResetPinN, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .pcStep, .pcValue, .portAIn,
		.portAOut, .portAOe, .portCIn, .portCOut, .portCOe);
	// small variant on the same bus, only its read data is watched
	core_and_port_register_map #(.HAS_PORT_C(1'b0)) uutSmall (.ref_clk, .nrst,
		.externalResetPinN, .psel, .penable, .pwrite, .paddr, .pwdata, .pready(),
		.prdata(prdataSmall), .pslverr(), .pcStep, .pcValue(), .portAIn, .portAOut(),
		.portAOe(), .portCIn, .portCOut(), .portCOe());
	// clock
	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// hang guard
	always @(posedge ref_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			failures++;
			results();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic rdchk(input logic [6:0] idx, input logic [7:0] e);
		m.xfer(1'b0, idx, 8'h00, q);
		chk(q, {24'h00_0000, e});
	endtask : rdchk
	task automatic wr(input logic [6:0] idx, input logic [7:0] d);
		m.xfer(1'b1, idx, d, q);
	endtask : wr
	// write then read back through the bus
	task automatic wrchk(input logic [6:0] idx, input logic [7:0] d, input logic [7:0] e);
		wr(idx, d);
		rdchk(idx, e);
	endtask : wrchk
	task reset_test;
		rdchk(OFF_FLAGS, 8'h18);
		rdchk(OFF_INT_CTRL, 8'h01);
		rdchk(OFF_PORT_A_PINS_DIR, 8'h37);
		rdchk(OFF_PORT_C_PINS_DIR, 8'h3f);
		rdchk(OFF_ACCUM, 8'h00);
		chk(32'(portAOe), 32'h0000_0000);
	endtask : reset_test
	task bank_test;
		wrchk(OFF_BANK_SEL, 8'hff, 8'h3f);
		wrchk(OFF_ACCUM, 8'h5c, 8'h5c);
		wr(OFF_BANK_SEL, 8'h05);
		rdchk(OFF_ACCUM, 8'h5c);
		wrchk(OFF_PORT_A_PINS_LAT, 8'h15, 8'h00);
		wr(OFF_BANK_SEL, 8'h00);
		rdchk(OFF_PORT_A_PINS_LAT, 8'h00);
		wrchk(7'h0d, 8'hff, 8'h00);
		wrchk(OFF_INT_CTRL, 8'hff, 8'hc1);
		wrchk(OFF_FLAGS, 8'hff, 8'h1f);
	endtask : bank_test
	task indirect_test;
		wr(GPR_FIRST, 8'h5a);
		wr(OFF_PTR0_HIGH, 8'h00);
		wr(OFF_PTR0_LOW, 8'h20);
		rdchk(OFF_INDIRECT0, 8'h5a);
		wr(OFF_PTR1_HIGH, 8'h00);
		wr(OFF_PTR1_LOW, 8'ha1);
		wr(OFF_INDIRECT1, 8'h33);
		wr(OFF_BANK_SEL, 8'h01);
		rdchk(7'h21, 8'h33);
		wr(OFF_PTR0_LOW, 8'h09);
		rdchk(OFF_INDIRECT0, 8'h5c);
		wr(OFF_PTR0_LOW, 8'h01);
		wrchk(OFF_INDIRECT0, 8'h77, 8'h00);
		wr(OFF_BANK_SEL, 8'h00);
	endtask : indirect_test
	task pc_test;
		wrchk(OFF_PC_LATCH, 8'hff, 8'h7f);
		chk(32'(pcValue), 32'h0000_0000);
		wr(OFF_PC_LOW, 8'h34);
		@(posedge ref_clk);
		chk(32'(pcValue), 32'h0000_7f34);
		@(posedge ref_clk) pcStep <= 1'b1;
		@(posedge ref_clk) pcStep <= 1'b0;
		rdchk(OFF_PC_LOW, 8'h35);
	endtask : pc_test
	task port_test;
		wr(OFF_PORT_A_PINS_DIR, 8'h00);
		wr(OFF_PORT_A_PINS_LAT, 8'hff);
		@(posedge ref_clk);
		chk(32'(portAOut), 32'h0000_0037);
		chk(32'(portAOe), 32'h0000_0037);
		rdchk(OFF_PORT_A_PINS_PINS, 8'h2a);
		rdchk(OFF_PORT_C_PINS_PINS, 8'h15);
		chk(prdataSmall, 32'h0000_0000);
		wrchk(OFF_PORT_C_PINS_LAT, 8'h3c, 8'h3c);
		chk(prdataSmall, 32'h0000_0000);
		wr(OFF_PORT_C_PINS_DIR, 8'h30);
		@(posedge ref_clk);
		chk(32'(portCOe), 32'h0000_000f);
		chk(32'(portCOut), 32'h0000_003c);
	endtask : port_test
	task ext_reset_test;
		wr(OFF_ACCUM, 8'ha5);
		wr(OFF_PTR0_LOW, 8'h11);
		wr(OFF_PTR0_HIGH, 8'h03);
		wr(OFF_BANK_SEL, 8'h02);
		@(posedge ref_clk) externalResetPinN <= 1'b0;
		repeat (4) @(posedge ref_clk);
		externalResetPinN <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rdchk(OFF_ACCUM, 8'ha5);
		rdchk(OFF_PTR0_LOW, 8'h11);
		rdchk(OFF_PTR0_HIGH, 8'h00);
		rdchk(OFF_BANK_SEL, 8'h00);
		rdchk(OFF_INT_CTRL, 8'h01);
	endtask : ext_reset_test
	task results;
		if (failures == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results
	// main sequence
	initial
	begin
		nrst = 1'b0;
		externalResetPinN = 1'b1;
		pcStep = 1'b0;
		portAIn = 6'h2a;
		portCIn = 6'h15;
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
		reset_test();
		bank_test();
		indirect_test();
		pc_test();
		port_test();
		ext_reset_test();
		results();
	end
endmodule : testbench
